// file: rtl/ebcs_ctrl.v
// external bus control strobes: bus cycle sequencer, hold and ready handling
`timescale 1ns/1ps
`include "ebcs_regs.vh"
module ebcs_ctrl #(
   parameter ADDR_W = `EBCS_ADDR_W,
   parameter DATA_W = `EBCS_DATA_W
) (
   // clock and reset
   input wire mclk,
   input wire sys_rst,
   // scheme select, high picks single strobe scheme
   input wire single_strobe_mode,
   // request side from the core
   input wire req_valid,
   input wire req_write,
   input wire [ADDR_W-1:0] req_addr,
   input wire [DATA_W-1:0] req_wdata,
   input wire [3:0] req_area,
   output reg req_ready,
   output reg rsp_valid,
   output reg [DATA_W-1:0] rsp_rdata,
   // external bus pins
   input wire hold_req_n,
   input wire wait_req_n,
   output reg bus_clk,
   output reg ale,
   output reg rd_n,
   output reg low_lane_store_strobe_n,
   output reg high_lane_store_strobe_n,
   output reg hold_grant_n,
   output reg [3:0] area_select_lines_n,
   output reg [ADDR_W-1:0] addr_o,
   output reg addr_oe_n,
   output reg strobe_oe_n,
   input wire [DATA_W-1:0] data_i,
   output reg [DATA_W-1:0] data_o,
   output reg data_oe_n
);
   // sequencer state
   reg [2:0] state;
   reg [2:0] next_state;
   // pin synchronisers
   reg hold_s1;
   reg hold_s2;
   reg wait_s1;
   reg wait_s2;
   // direction of the cycle in flight
   reg cur_write;
   // decoded conditions
   wire hold_now;
   wire wait_now;
   wire st_idle;
   wire st_addr;
   wire st_data;
   wire st_end;
   wire take_req;
   wire enter_hold;
   wire data_done;
   wire odd_lane;

   assign hold_now = ~hold_s2;
   assign wait_now = ~wait_s2;
   assign st_idle = (state == `EBCS_ST_IDLE);
   assign st_addr = (state == `EBCS_ST_ADDR);
   assign st_data = (state == `EBCS_ST_DATA);
   assign st_end = (state == `EBCS_ST_END);
   assign take_req = st_idle & (next_state == `EBCS_ST_ADDR);
   assign enter_hold = (next_state == `EBCS_ST_HOLD);
   assign data_done = st_data & ~wait_now;
   // lane is taken from the latched address, not the live request
   assign odd_lane = addr_o[`EBCS_LANE_BIT];

   // hold pin: two flops, only the second is read
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         hold_s1 <= 1'h1;
         hold_s2 <= 1'h1;
      end else begin
         hold_s1 <= hold_req_n;
         hold_s2 <= hold_s1;
      end
   end

   // wait pin: two flops, costs two cycles of stretch latency
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         wait_s1 <= 1'h1;
         wait_s2 <= 1'h1;
      end else begin
         wait_s1 <= wait_req_n;
         wait_s2 <= wait_s1;
      end
   end

   // hold is only taken between cycles so a started transfer always completes
   always @* begin
      next_state = state;
      case (state)
         `EBCS_ST_IDLE: begin
            if (hold_now)
               next_state = `EBCS_ST_HOLD;
            else if (req_valid)
               next_state = `EBCS_ST_ADDR;
         end
         `EBCS_ST_ADDR: next_state = `EBCS_ST_DATA;
         `EBCS_ST_DATA: begin
            if (!wait_now)
               next_state = `EBCS_ST_END;
         end
         `EBCS_ST_END: next_state = `EBCS_ST_IDLE;
         `EBCS_ST_HOLD: begin
            if (!hold_now)
               next_state = `EBCS_ST_IDLE;
         end
         default: next_state = `EBCS_ST_IDLE;
      endcase
   end

   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= `EBCS_ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // free-running bus clock at half the core clock
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         bus_clk <= 1'h0;
      end else begin
         bus_clk <= bus_clk ^ `EBCS_BCLK_HALF;
      end
   end

   // one-cycle latch pulse while the address is first put out
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         ale <= 1'h0;
      end else if (take_req) begin
         ale <= 1'h1;
      end else if (st_addr) begin
         ale <= 1'h0;
      end
   end

   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         rd_n <= 1'h1;
      end else if (st_addr && !cur_write) begin
         rd_n <= 1'h0;
      end else if (data_done) begin
         rd_n <= 1'h1;
      end
   end

   // in the single scheme this pin is the one store strobe
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         low_lane_store_strobe_n <= 1'h1;
      end else if (st_addr && cur_write) begin
         if (single_strobe_mode) begin
            low_lane_store_strobe_n <= 1'h0;
         end else begin
            low_lane_store_strobe_n <= odd_lane;
         end
      end else if (data_done) begin
         low_lane_store_strobe_n <= 1'h1;
      end
   end

   // in the single scheme this pin is the upper lane enable, for reads too
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         high_lane_store_strobe_n <= 1'h1;
      end else if (st_addr && (cur_write || single_strobe_mode)) begin
         if (single_strobe_mode) begin
            high_lane_store_strobe_n <= ~odd_lane;
         end else begin
            high_lane_store_strobe_n <= ~odd_lane;
         end
      end else if (data_done) begin
         high_lane_store_strobe_n <= 1'h1;
      end
   end

   // grant and release follow the state being entered, so they move together
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         hold_grant_n <= 1'h1;
         addr_oe_n <= 1'h0;
         strobe_oe_n <= 1'h0;
      end else begin
         hold_grant_n <= ~enter_hold;
         addr_oe_n <= enter_hold;
         strobe_oe_n <= enter_hold;
      end
   end

   // selects stay low through any wait stretch, cleared at cycle end
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         area_select_lines_n <= `EBCS_AREA_NONE;
      end else if (take_req) begin
         area_select_lines_n <= ~req_area;
      end else if (st_end) begin
         area_select_lines_n <= `EBCS_AREA_NONE;
      end
   end

   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         addr_o <= {ADDR_W{1'b0}};
      end else if (take_req) begin
         addr_o <= req_addr;
      end
   end

   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         data_o <= {DATA_W{1'b0}};
      end else if (take_req) begin
         data_o <= req_wdata;
      end
   end

   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         cur_write <= 1'h0;
      end else if (take_req) begin
         cur_write <= req_write;
      end
   end

   // data held one more cycle past the strobe for hold time
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         data_oe_n <= 1'h1;
      end else if (st_addr && cur_write) begin
         data_oe_n <= 1'h0;
      end else if (!st_addr && !st_data) begin
         data_oe_n <= 1'h1;
      end
   end

   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         req_ready <= 1'h0;
      end else begin
         req_ready <= take_req;
      end
   end

   // reads finish at strobe release, writes one cycle later
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         rsp_valid <= 1'h0;
      end else begin
         rsp_valid <= (data_done & ~cur_write) | (st_end & cur_write);
      end
   end

   // read data is taken on the same edge that raises the load strobe
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         rsp_rdata <= {DATA_W{1'b0}};
      end else if (data_done && !cur_write) begin
         rsp_rdata <= data_i;
      end
   end
endmodule

// file: rtl/ebcs_regs.vh
// constants for the external bus control strobe block
`ifndef EBCS_REGS_VH
`define EBCS_REGS_VH
`define EBCS_ST_IDLE 3'h0
`define EBCS_ST_ADDR 3'h1
`define EBCS_ST_DATA 3'h2
`define EBCS_ST_END 3'h3
`define EBCS_ST_HOLD 3'h4
`define EBCS_ADDR_W 20
`define EBCS_DATA_W 16
`define EBCS_AREA_W 4
`define EBCS_AREA_NONE 4'hF
`define EBCS_BCLK_HALF 1'h1
`define EBCS_LANE_BIT 0
`endif

// file: tb/ebcs_ctrl_assertions.sv
// pin checker for the bus strobes
`timescale 1ns/1ps
module ebcs_ctrl_assertions(
   input wire mclk, sys_rst, single_strobe_mode, hold_req_n, wait_req_n, rsp_valid, ale, rd_n, bus_clk,
   input wire hold_grant_n, addr_oe_n, strobe_oe_n, low_lane_store_strobe_n, high_lane_store_strobe_n,
   input wire [3:0] area_select_lines_n,
   input wire [19:0] addr_o
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   AST_OE: assert property (!hold_grant_n |-> addr_oe_n && strobe_oe_n) else $error("oe");
   AST_GNT: assert property (!hold_req_n [*8] |-> !hold_grant_n) else $error("gnt");
   AST_UNGNT: assert property (hold_req_n [*4] |-> hold_grant_n) else $error("ungnt");
   AST_RD: assert property ($rose(rd_n) |-> rsp_valid) else $error("rd");
   AST_LO: assert property (!single_strobe_mode && !low_lane_store_strobe_n |-> !addr_o[0]) else $error("lo");
   AST_HI: assert property (!single_strobe_mode && !high_lane_store_strobe_n |-> addr_o[0]) else $error("hi");
   AST_ALE: assert property (ale |-> area_select_lines_n != 4'hF ##1 !ale) else $error("ale");
   AST_WT: assert property (!wait_req_n [*4] ##0 !rd_n |=> !rd_n && $stable(addr_o)) else $error("wt");
   AST_BCLK: assert property (!$past(sys_rst) |-> bus_clk != $past(bus_clk)) else $error("bclk");
endmodule

// file: tb/ebcs_mem_model.sv
// far-side memory that can stretch reads
`timescale 1ns/1ps
module ebcs_mem_model(input wire mclk, rd_n, input wire [19:0] addr_o, input wire [1:0] slow,
   output reg wait_req_n = 1, output wire [15:0] data_i);
   reg [15:0] junk = 0;
   reg [1:0] cnt = 0;
   // bus churns when not read, so stale data never matches
   assign data_i = rd_n ? junk : addr_o[15:0] ^ 16'h5A5A;
   always @(posedge mclk) begin
      junk <= ~junk;
      cnt <= rd_n ? 2'h0 : cnt + (cnt != slow);
      wait_req_n <= slow == 0 || (!rd_n && cnt == slow);
   end
endmodule

// file: tb/ebcs_ctrl_tb_top.sv
// self-checking bench for the strobe sequencer
`timescale 1ns/1ps
module ebcs_ctrl_tb_top;
   reg mclk = 0, sys_rst = 1, single_strobe_mode = 0, req_valid = 0, req_write = 0, hold_req_n = 1;
   reg [19:0] req_addr = 0;
   reg [15:0] req_wdata = 0, wd;
   reg [3:0] req_area = 0, sel;
   reg [1:0] slow = 0;
   reg [2:0] seen;
   wire req_ready, rsp_valid, bus_clk, ale, rd_n, low_lane_store_strobe_n, high_lane_store_strobe_n;
   wire hold_grant_n, addr_oe_n, strobe_oe_n, data_oe_n, wait_req_n;
   wire [15:0] rsp_rdata, data_i, data_o;
   wire [19:0] addr_o;
   wire [3:0] area_select_lines_n;
   integer error_cnt = 0, tests_run = 0, i;
   ebcs_ctrl u_ebcs_ctrl(.mclk(mclk), .sys_rst(sys_rst), .single_strobe_mode(single_strobe_mode),
      .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
      .req_area(req_area), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .hold_req_n(hold_req_n), .wait_req_n(wait_req_n), .bus_clk(bus_clk), .ale(ale), .rd_n(rd_n),
      .low_lane_store_strobe_n(low_lane_store_strobe_n), .high_lane_store_strobe_n(high_lane_store_strobe_n),
      .hold_grant_n(hold_grant_n), .area_select_lines_n(area_select_lines_n), .addr_o(addr_o),
      .addr_oe_n(addr_oe_n), .strobe_oe_n(strobe_oe_n), .data_i(data_i), .data_o(data_o), .data_oe_n(data_oe_n));
   ebcs_mem_model u_ebcs_mem_model(.mclk(mclk), .rd_n(rd_n), .addr_o(addr_o), .slow(slow),
      .wait_req_n(wait_req_n), .data_i(data_i));
   initial forever #20 mclk = ~mclk;
   task chk(input string n, input [19:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s exp %h got %h", n, exp, got);
      end
   endtask
   task complete_run;
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task xfer(input w, input [19:0] a, input [3:0] ar);
      {seen, sel} = 7'h7F;
      {req_valid, req_write, req_addr, req_area, req_wdata} <= {1'b1, w, a, ar, ~a[15:0]};
      for (i = 0; i < 40; i++) begin
         @(posedge mclk);
         if (req_ready) req_valid <= 0;
         seen &= {rd_n, low_lane_store_strobe_n, high_lane_store_strobe_n};
         sel &= area_select_lines_n;
         if (!data_oe_n) wd = data_o;
         if (rsp_valid) break;
      end
      if (i == 40) begin
         error_cnt++;
         complete_run;
      end
      chk("lanes", seen, {w, !(w && (single_strobe_mode || !a[0])), !(a[0] && (single_strobe_mode || w))});
      chk("area", sel, {~ar});
      chk("data", w ? wd : rsp_rdata, w ? {~a[15:0]} : a[15:0] ^ 16'h5A5A);
   endtask
   initial begin
      repeat (12) @(posedge mclk);
      sys_rst <= 0;
      for (int k = 0; k < 8; k++) begin
         single_strobe_mode <= k[2];
         xfer(k[1], 20'hABC40 + k, 4'h1 << k[1:0]);
      end
      $display("schemes done");
      slow <= 3;
      repeat (2) @(posedge mclk);
      xfer(0, 20'h00301, 4'h8);
      slow <= 0;
      $display("stretch done");
      hold_req_n <= 0;
      repeat (10) @(posedge mclk);
      chk("hold", {hold_grant_n, addr_oe_n, strobe_oe_n}, 3'h3);
      hold_req_n <= 1;
      repeat (5) @(posedge mclk);
      chk("free", {hold_grant_n, addr_oe_n}, 2'h2);
      $display("hold done");
      complete_run;
   end
endmodule
bind ebcs_ctrl ebcs_ctrl_assertions u_ebcs_ctrl_assertions(.*);
